// ===== common/apt_defines.svh
// Constants for the associative page translation block
`ifndef APT_DEFINES_SVH
`define APT_DEFINES_SVH

// Operation codes
`define APT_OP_STORE 8'h0c
`define APT_OP_LOAD 8'h0d
`define APT_OP_XLATE 8'h0f

// Save area in central storage
`define APT_SAVE_BASE 48'h00_0000_4000
`define APT_SAVE_STEP 48'h00_0000_0040

// Associative file geometry
`define APT_NWORDS 16
`define APT_LAST_IDX 4'hf
`define APT_NKEYS 4
`define APT_KEY_W 8

// Associative word fields
`define APT_W_KEY 63:56
`define APT_W_VPAGE 55:32
`define APT_W_APAGE 31:8

// Virtual address and result fields
`define APT_VA_HIGH 63:48
`define APT_VA_PAGE 47:24
`define APT_VA_OFF 23:0
`define APT_VA_LOW 47:0

`endif

// ===== common/apt_pkg.sv
// Types shared by the associative page translation block
package apt_pkg;

  typedef enum logic [1:0] {
    APT_S_IDLE = 2'b00,
    APT_S_STORE = 2'b01,
    APT_S_LOAD = 2'b10,
    APT_S_SEARCH = 2'b11
  } apt_state_t;

endpackage

// ===== rtl/apt_unit.sv
// Associative page-table registers: save, restore, key load and address translation
`timescale 1ns/10ps
`include "apt_defines.svh"


module apt_unit import apt_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Operation request
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic monitor_mode,
  input wire logic [47:0] prog_addr,
  input wire logic [63:0] key_src,
  input wire logic [63:0] vaddr_src,
  output logic op_ready,
  output logic op_done,
  output logic [63:0] result,
  // Job-mode exchange request
  output logic trap_valid,
  output logic [7:0] trap_code,
  output logic [47:0] trap_paddr,
  // Central storage port
  output logic mem_req,
  output logic mem_we,
  output logic [47:0] mem_addr,
  output logic [63:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata
);

  apt_state_t state, next_state;
  logic [3:0] idx, next_idx;
  logic [63:0] assoc [`APT_NWORDS];
  logic [63:0] next_assoc [`APT_NWORDS];
  logic [`APT_KEY_W-1:0] keys [`APT_NKEYS];
  logic [`APT_KEY_W-1:0] next_keys [`APT_NKEYS];
  logic [63:0] vreg, next_vreg;
  logic next_op_ready, next_op_done, next_trap_valid;
  logic [7:0] next_trap_code;
  logic [47:0] next_trap_paddr;
  logic [63:0] next_result;
  logic next_mem_req, next_mem_we;
  logic [47:0] next_mem_addr;
  logic [63:0] next_mem_wdata;
  logic [63:0] cur_word;
  logic [`APT_NKEYS-1:0] key_match;
  logic hit, take, priv, xfer_ack;
  logic [47:0] hit_abs;

  // Search probe: one associative word per cycle, lowest index first
  assign cur_word = assoc[idx];
  genvar k;
  generate
    for (k = 0; k < `APT_NKEYS; k = k + 1) begin : g_key
      assign key_match[k] = (cur_word[`APT_W_KEY] == keys[k]);
    end
  endgenerate
  assign hit = (state == APT_S_SEARCH) && (|key_match) &&
               (cur_word[`APT_W_VPAGE] == vreg[`APT_VA_PAGE]);
  assign hit_abs = {cur_word[`APT_W_APAGE], vreg[`APT_VA_OFF]};
  assign take = op_valid && op_ready;
  // Only the three associative codes are privileged here; any other code is dropped
  assign priv = (op_code == `APT_OP_STORE) || (op_code == `APT_OP_LOAD) || (op_code == `APT_OP_XLATE);
  // An acknowledge counts only while a request stands; a stray one must not step the sequence
  assign xfer_ack = mem_req && mem_ack;

  // Sequencer next values
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_vreg = vreg;
    next_keys = keys;
    next_op_ready = op_ready;
    next_op_done = 1'b0;
    next_result = result;
    next_trap_valid = 1'b0;
    next_trap_code = trap_code;
    next_trap_paddr = trap_paddr;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    case (state)
      APT_S_IDLE: begin
        if (take && priv && !monitor_mode) begin
          // Job mode sees these as undefined codes and exchanges out
          next_trap_valid = 1'b1;
          next_trap_code = op_code;
          next_trap_paddr = prog_addr;
        end else if (take && priv) begin
          next_idx = 4'h0;
          next_op_ready = 1'b0;
          case (op_code)
            `APT_OP_STORE: begin
              next_state = APT_S_STORE;
              next_mem_req = 1'b1;
              next_mem_we = 1'b1;
              next_mem_addr = `APT_SAVE_BASE;
              next_mem_wdata = assoc[0];
            end
            `APT_OP_LOAD: begin
              next_state = APT_S_LOAD;
              next_mem_req = 1'b1;
              next_mem_we = 1'b0;
              next_mem_addr = `APT_SAVE_BASE;
            end
            default: begin
              // Keys land before the first probe, so the search sees them
              next_state = APT_S_SEARCH;
              for (int i = 0; i < `APT_NKEYS; i++) begin
                next_keys[i] = key_src[i*`APT_KEY_W +: `APT_KEY_W];
              end
              next_vreg = vaddr_src;
            end
          endcase
        end
      end
      APT_S_STORE, APT_S_LOAD: begin
        if (xfer_ack) begin
          if (idx == `APT_LAST_IDX) begin
            next_state = APT_S_IDLE;
            next_mem_req = 1'b0;
            next_mem_we = 1'b0;
            next_op_ready = 1'b1;
            next_op_done = 1'b1;
          end else begin
            next_idx = idx + 4'h1;
            next_mem_addr = mem_addr + `APT_SAVE_STEP;
            next_mem_wdata = assoc[idx + 4'h1];
          end
        end
      end
      APT_S_SEARCH: begin
        if (hit) begin
          next_result = {vreg[`APT_VA_HIGH], hit_abs};
          next_state = APT_S_IDLE;
          next_op_ready = 1'b1;
          next_op_done = 1'b1;
        end else if (idx == `APT_LAST_IDX) begin
          next_result = {vreg[`APT_VA_HIGH], 48'h0000_0000_0000};
          next_state = APT_S_IDLE;
          next_op_ready = 1'b1;
          next_op_done = 1'b1;
        end else begin
          next_idx = idx + 4'h1;
        end
      end
      default: begin
        next_state = APT_S_IDLE;
        next_op_ready = 1'b1;
        next_mem_req = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= APT_S_IDLE;
      idx <= 4'h0;
      vreg <= 64'h0;
      for (int i = 0; i < `APT_NKEYS; i++) begin
        keys[i] <= 8'h00;
      end
      op_ready <= 1'b1;
      op_done <= 1'b0;
      result <= 64'h0;
      trap_valid <= 1'b0;
      trap_code <= 8'h00;
      trap_paddr <= 48'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 48'h0;
      mem_wdata <= 64'h0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      vreg <= next_vreg;
      keys <= next_keys;
      op_ready <= next_op_ready;
      op_done <= next_op_done;
      result <= next_result;
      trap_valid <= next_trap_valid;
      trap_code <= next_trap_code;
      trap_paddr <= next_trap_paddr;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // Associative file: restore, and move-to-front on a hit.
  // A store leaves the words as they were; software must treat them as undefined anyway.
  genvar j;
  generate
    for (j = 0; j < `APT_NWORDS; j = j + 1) begin : g_word
      always_comb begin
        next_assoc[j] = assoc[j];
        if (state == APT_S_LOAD && xfer_ack && idx == 4'(j)) begin
          next_assoc[j] = mem_rdata;
        end else if (hit) begin
          // Every slot reads the old contents, so the shift and the move happen in one edge
          if (j == 0) begin
            next_assoc[j] = cur_word;
          end else if (4'(j) <= idx) begin
            next_assoc[j] = assoc[(j == 0) ? 0 : j - 1];
          end
        end
      end
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          assoc[j] <= 64'h0;
        end else begin
          assoc[j] <= next_assoc[j];
        end
      end
    end
  endgenerate

  // Checks on the sequencer and the associative file
  default clocking apt_cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  store_write_a: assert property ((state == APT_S_STORE) |-> (mem_req && mem_we))
    else $error("store sequence not writing");
  save_order_a: assert property (mem_req |-> (mem_addr == `APT_SAVE_BASE + {38'h0, idx, 6'h00}))
    else $error("save area address out of order");
  load_capture_a: assert property ((state == APT_S_LOAD && mem_ack) |=> (assoc[$past(idx)] == $past(mem_rdata)))
    else $error("restored word not captured");
  key_load_a: assert property ((take && monitor_mode && op_code == `APT_OP_XLATE)
                                |=> (keys[0] == $past(key_src[7:0]) && keys[3] == $past(key_src[31:24])))
    else $error("keys not loaded");
  hit_addr_a: assert property (hit |=> (op_done && result[47:0] == $past(hit_abs)))
    else $error("hit address wrong");
  miss_zero_a: assert property ((state == APT_S_SEARCH && !hit && idx == `APT_LAST_IDX)
                                 |=> (op_done && result[47:0] == 48'h0))
    else $error("miss did not clear result");
  upper_copy_a: assert property ((state == APT_S_SEARCH) ##1 op_done |-> (result[63:48] == vreg[63:48]))
    else $error("upper address bits not copied");
  promote_top_a: assert property (hit |=> (assoc[0] == $past(cur_word)))
    else $error("hit word not promoted");
  shift_down_a: assert property ((hit && idx != 4'h0) |=> (assoc[1] == $past(assoc[0])))
    else $error("preceding words not shifted");
  job_trap_a: assert property ((take && priv && !monitor_mode)
                                |=> (trap_valid && trap_code == $past(op_code) && state == APT_S_IDLE))
    else $error("job mode did not trap");
  search_bound_a: assert property ((take && monitor_mode && op_code == `APT_OP_XLATE) |-> ##[2:17] op_done)
    else $error("search did not end in sixteen probes");

  // Storage handshake: the request stands until taken, and the sixteenth word ends the run
  req_hold_a: assert property ((mem_req && !mem_ack)
                                |=> (mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata)))
    else $error("storage request changed before acknowledge");
  load_read_a: assert property ((state == APT_S_LOAD) |-> (mem_req && !mem_we))
    else $error("restore sequence not reading");
  xfer_end_a: assert property (((state == APT_S_STORE || state == APT_S_LOAD) && xfer_ack && idx == `APT_LAST_IDX)
                                |=> (op_done && !mem_req && state == APT_S_IDLE))
    else $error("save or restore did not end after sixteen words");
  ready_busy_a: assert property ((state != APT_S_IDLE) |-> !op_ready)
    else $error("ready shown while busy");

  // Translation start, search and promotion
  key_mid_a: assert property ((take && monitor_mode && op_code == `APT_OP_XLATE)
                               |=> (keys[1] == $past(key_src[15:8]) && keys[2] == $past(key_src[23:16])))
    else $error("middle keys not loaded");
  xlate_start_a: assert property ((take && monitor_mode && op_code == `APT_OP_XLATE)
                                   |=> (state == APT_S_SEARCH && idx == 4'h0 && vreg == $past(vaddr_src)))
    else $error("search did not start at word zero");
  shift_end_a: assert property ((hit && idx == `APT_LAST_IDX) |=> (assoc[15] == $past(assoc[14])))
    else $error("last word not shifted down");
  miss_keep_a: assert property ((state == APT_S_SEARCH && !hit) |=> (assoc[0] == $past(assoc[0])))
    else $error("top word moved without a hit");

  // A job-mode attempt changes nothing but the trap outputs
  job_quiet_a: assert property ((take && priv && !monitor_mode)
                                 |=> (op_ready && !mem_req && !op_done && $stable(vreg) && $stable(result)))
    else $error("job mode attempt changed unit state");

  store_seen_c: cover property ((state == APT_S_STORE) ##1 (state == APT_S_IDLE));
  load_seen_c: cover property ((state == APT_S_LOAD) ##1 (state == APT_S_IDLE));
  hit_deep_c: cover property (hit && idx == 4'h5);
  miss_seen_c: cover property ((state == APT_S_SEARCH) ##1 (op_done && result[47:0] == 48'h0));
  trap_seen_c: cover property (trap_valid);

endmodule

// ===== testbench/apt_mem_model.sv
// Central storage model that holds the associative save area
`timescale 1ns/10ps
module apt_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Storage port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [47:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  output logic mem_ack,
  output logic [63:0] mem_rdata,
  // Extra wait cycles before each acknowledge
  input wire logic [3:0] ack_wait
);
  logic [63:0] words [0:15];
  logic [47:0] addr_log [0:15];
  int n_acc = 0;
  logic [3:0] waited;
  logic [3:0] idx;
  // Word index from the save-area address; a stray address folds into the table
  assign idx = 4'((mem_addr - 48'h00_0000_4000) >> 6);

  // Ack after the set wait; read data toggles outside the ack cycle so stale data never matches
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      waited <= 4'h0;
      mem_rdata <= 64'h0;
    end else begin
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      if (mem_req && mem_ack) begin
        if (mem_we) begin
          words[idx] <= mem_wdata;
        end
        addr_log[n_acc[3:0]] <= mem_addr;
        n_acc <= n_acc + 1;
        waited <= 4'h0;
      end else if (mem_req && waited >= ack_wait) begin
        mem_ack <= 1'b1;
        mem_rdata <= words[idx];
      end else if (mem_req) begin
        waited <= waited + 4'h1;
      end
    end
  end
endmodule

// ===== testbench/apt_unit_tb_top.sv
// Self-checking bench for the associative page translation unit
`timescale 1ns/10ps
module apt_unit_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic op_valid = 1'b0;
  logic [7:0] op_code = 8'h00;
  logic monitor_mode = 1'b1;
  logic [47:0] prog_addr = 48'h0;
  logic [63:0] key_src = 64'h0;
  logic [63:0] vaddr_src = 64'h0;
  logic [3:0] ack_wait = 4'h0;
  logic op_ready, op_done, trap_valid, mem_req, mem_we, mem_ack;
  logic [63:0] result, mem_wdata, mem_rdata;
  logic [7:0] trap_code;
  logic [47:0] trap_paddr, mem_addr;
  int fails = 0;
  int checked = 0;
  int lat;

  always #20 ref_clk = ~ref_clk;

  apt_unit dut_u (.ref_clk(ref_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
    .monitor_mode(monitor_mode), .prog_addr(prog_addr), .key_src(key_src), .vaddr_src(vaddr_src),
    .op_ready(op_ready), .op_done(op_done), .result(result), .trap_valid(trap_valid),
    .trap_code(trap_code), .trap_paddr(trap_paddr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  apt_mem_model mem_u (.ref_clk(ref_clk), .resetn(resetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .ack_wait(ack_wait));

  // Word i maps page 100+i to 0a00+i; word 5 carries a key outside the loaded set
  function automatic logic [63:0] wd(input int i);
    wd = {(i == 5) ? 8'h77 : 8'h5a, 24'h000100 + 24'(i), 24'h000a00 + 24'(i), 8'h00};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One request; no designator fields reach these ports, so none need clearing
  task automatic run_op(input logic [7:0] code, input logic mon, input logic [63:0] va);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = code;
    monitor_mode = mon;
    vaddr_src = va;
    key_src = 64'hffff_ffff_115a_2233;
    prog_addr = {40'h00_0000_0abc, code};
    @(negedge ref_clk);
    op_valid = 1'b0;
    lat = 1;
    while (op_done !== 1'b1 && trap_valid !== 1'b1 && lat < 400) begin
      @(negedge ref_clk);
      lat++;
    end
  endtask

  task automatic check_log;
    for (int i = 0; i < 16; i++) begin
      check({16'h0, mem_u.addr_log[i]}, 64'h4000 + 64'h40 * 64'(i));
    end
  endtask

  // Translate page 100+j; pages 105 (wrong key) and 110 (absent) miss
  task automatic xl(input int j, input int exp_lat);
    logic [63:0] exp;
    exp = (j == 5 || j == 16) ? 64'hbeef_0000_0000_0000 : {16'hbeef, 24'h000a00 + 24'(j), 24'h123456};
    run_op(8'h0f, 1'b1, {16'hbeef, 24'h000100 + 24'(j), 24'h123456});
    check(64'(lat), 64'(exp_lat));
    check(result, exp);
  endtask

  task automatic t_xlate;
    run_op(8'h0d, 1'b1, 64'h0);
    check(64'(lat), 64'd33);
    check_log;
    xl(3, 5);
    xl(3, 2);
    xl(0, 3);
    xl(2, 5);
    xl(1, 5);
    xl(15, 17);
    xl(5, 17);
    xl(16, 17);
    $display("load and translate test done");
  endtask

  task automatic t_trap;
    int base;
    base = mem_u.n_acc;
    for (int c = 0; c < 3; c++) begin
      run_op((c == 0) ? 8'h0c : (c == 1) ? 8'h0d : 8'h0f, 1'b0, {16'h0, 24'h000102, 24'h0});
      check(64'(lat), 64'h1);
      check({56'h0, trap_code}, {56'h0, op_code});
      check({16'h0, trap_paddr}, {16'h0, prog_addr});
      check({63'h0, op_ready}, 64'h1);
    end
    // An unlisted code in monitor mode is taken and dropped with no answer
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = 8'h0e;
    monitor_mode = 1'b1;
    @(negedge ref_clk);
    op_valid = 1'b0;
    check({61'h0, op_ready, op_done | trap_valid, mem_req}, 64'h4);
    check(64'(mem_u.n_acc), 64'(base));
    xl(15, 2);
    $display("job mode test done");
  endtask

  // Slow storage on save; table order is 15,1,2,0,3..14 from the promotions above
  task automatic t_store;
    ack_wait = 4'h2;
    run_op(8'h0c, 1'b1, 64'h0);
    check(64'(lat), 64'd65);
    check_log;
    for (int p = 0; p < 16; p++) begin
      check(mem_u.words[p], wd((p == 0) ? 15 : (p == 3) ? 0 : (p < 3) ? p : p - 1));
    end
    ack_wait = 4'h0;
    run_op(8'h0d, 1'b1, 64'h0);
    check(64'(lat), 64'd33);
    xl(0, 5);
    $display("store test done");
  endtask

  task automatic test_done;
    $display("Counts: %0d checked, %0d failed", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence after six cycles of reset
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_u.words[i] = wd(i);
    end
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    check({63'h0, op_ready}, 64'h1);
    t_xlate;
    t_trap;
    t_store;
    test_done;
  end

  // Cut a hang short; the run needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    fails++;
    test_done;
  end
endmodule
